/* design/tta_top.sv */
// turn-around timing block with its AXI4-Lite register slave
`timescale 1ns/1ns
module tta_top (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [tta_pkg::TTA_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [tta_pkg::TTA_DATA_W-1:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [tta_pkg::TTA_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [tta_pkg::TTA_DATA_W-1:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_done,
    input wire logic frame_good,
    input wire logic frame_ack_req,
    input wire logic frame_data_or_cmd,
    output logic rx_enable,
    output logic ack_tx_start,
    output logic wait_busy,
    output logic ack_busy
);
    import tta_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // register state

    logic [31:0] cfg_r;
    logic [31:0] cfg_nxt;
    logic [31:0] ctrl_r;
    logic [31:0] ctrl_nxt;

    logic aw_held_r;
    logic aw_held_nxt;
    logic [TTA_ADDR_W-1:0] aw_addr_r;
    logic [TTA_ADDR_W-1:0] aw_addr_nxt;
    logic w_held_r;
    logic w_held_nxt;
    logic [31:0] w_data_r;
    logic [31:0] w_data_nxt;
    logic [3:0] w_strb_r;
    logic [3:0] w_strb_nxt;
    logic awready_r;
    logic awready_nxt;
    logic wready_r;
    logic wready_nxt;
    logic bvalid_r;
    logic bvalid_nxt;
    logic [1:0] bresp_r;
    logic [1:0] bresp_nxt;

    logic arready_r;
    logic arready_nxt;
    logic rvalid_r;
    logic rvalid_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0] rresp_r;
    logic [1:0] rresp_nxt;

    logic wr_fire;
    logic [31:0] wmask;
    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic [31:0] status_word;

    ////////////////////////////////////////////////////////////////////////
    // sequencer state

    tta_seq_t w_st_r;
    tta_seq_t w_st_nxt;
    tta_seq_t a_st_r;
    tta_seq_t a_st_nxt;
    logic rx_en_r;
    logic rx_en_nxt;
    logic ack_r;
    logic ack_nxt;

    logic [TTA_WAIT_W-1:0] wait_delay;
    logic [TTA_ACK_W-1:0] ack_delay;
    logic [TTA_SYM_W-1:0] sym_len;
    logic wait_en;
    logic w_load;
    logic a_load;
    logic ack_ok;
    logic sys_tick;
    logic unit_tick;
    logic sym_tick;
    logic w_done;
    logic a_done;

    assign wait_delay = cfg_r[TTA_WAIT_LSB +: TTA_WAIT_W];
    assign ack_delay = cfg_r[TTA_ACK_LSB +: TTA_ACK_W];
    assign sym_len = ctrl_r[TTA_CTRL_SYM_LSB +: TTA_SYM_W];
    assign wait_en = ctrl_r[TTA_CTRL_WAIT_EN_BIT];

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite write channel

    assign aw_idx = {2'b00, aw_addr_r[TTA_ADDR_W-1:2]};
    assign wr_fire = aw_held_r && w_held_r && !bvalid_r;
    assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}}, {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

    always_comb begin
        aw_held_nxt = aw_held_r;
        aw_addr_nxt = aw_addr_r;
        w_held_nxt = w_held_r;
        w_data_nxt = w_data_r;
        w_strb_nxt = w_strb_r;
        bvalid_nxt = bvalid_r;
        bresp_nxt = bresp_r;
        cfg_nxt = cfg_r;
        ctrl_nxt = ctrl_r;
        if (s_axi_awvalid && awready_r) begin
            aw_held_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_r) begin
            w_held_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (wr_fire) begin
            aw_held_nxt = 1'b0;
            w_held_nxt = 1'b0;
            bvalid_nxt = 1'b1;
            bresp_nxt = TTA_RESP_OKAY;
            case (aw_idx)
                TTA_IDX_TURN_CFG: begin
                    cfg_nxt = ((cfg_r & ~wmask) | (w_data_r & wmask)) & TTA_CFG_MASK;
                end
                TTA_IDX_CTRL: begin
                    ctrl_nxt = ((ctrl_r & ~wmask) | (w_data_r & wmask)) & TTA_CTRL_MASK;
                end
                TTA_IDX_RSVD_A, TTA_IDX_RSVD_B, TTA_IDX_STATUS: begin
                    bresp_nxt = TTA_RESP_OKAY;
                end
                default: begin
                    bresp_nxt = TTA_RESP_SLVERR;
                end
            endcase
        end
        // one write in flight; ready drops while held or answering
        awready_nxt = !aw_held_nxt && !bvalid_nxt;
        wready_nxt = !w_held_nxt && !bvalid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // AXI4-Lite read channel

    assign ar_idx = {2'b00, s_axi_araddr[TTA_ADDR_W-1:2]};
    assign status_word = {30'h00000000, (a_st_r == TTA_SEQ_WAIT), (w_st_r == TTA_SEQ_WAIT)};

    always_comb begin
        rvalid_nxt = rvalid_r;
        rdata_nxt = rdata_r;
        rresp_nxt = rresp_r;
        if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && arready_r) begin
            rvalid_nxt = 1'b1;
            rresp_nxt = TTA_RESP_OKAY;
            case (ar_idx)
                TTA_IDX_TURN_CFG: begin
                    rdata_nxt = cfg_r;
                end
                TTA_IDX_CTRL: begin
                    rdata_nxt = ctrl_r;
                end
                TTA_IDX_STATUS: begin
                    rdata_nxt = status_word;
                end
                TTA_IDX_RSVD_A, TTA_IDX_RSVD_B: begin
                    rdata_nxt = 32'h00000000;
                end
                default: begin
                    rdata_nxt = 32'h00000000;
                    rresp_nxt = TTA_RESP_SLVERR;
                end
            endcase
        end
        arready_nxt = !rvalid_nxt;
    end

    ////////////////////////////////////////////////////////////////////////
    // time base

    tta_tick_div #(.W(TTA_DIV_W)) u_sys_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(1'b0),
        .en(1'b1),
        .period(TTA_DIV_W'(TTA_SYSCLK_DIV)),
        .tick(sys_tick)
    );

    // unit of 128 system clocks, restarted on load
    tta_tick_div #(.W(TTA_DIV_W)) u_unit_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(w_load),
        .en(sys_tick),
        .period(TTA_DIV_W'(TTA_UNIT_SYS_CYCLES)),
        .tick(unit_tick)
    );

    tta_tick_div #(.W(TTA_DIV_W)) u_sym_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .clr(a_load),
        .en(sys_tick),
        .period(sym_len),
        .tick(sym_tick)
    );

    tta_unit_count #(.W(TTA_WAIT_W)) u_wait_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(w_load),
        .load_val(wait_delay),
        .tick(unit_tick),
        .done(w_done)
    );

    tta_unit_count #(.W(TTA_ACK_W)) u_ack_cnt (
        .aclk(aclk),
        .aresetn(aresetn),
        .load(a_load),
        .load_val(ack_delay),
        .tick(sym_tick),
        .done(a_done)
    );

    ////////////////////////////////////////////////////////////////////////
    // sequencers

    // only filtered frames that ask for one
    assign ack_ok = frame_good && frame_ack_req && frame_data_or_cmd;

    always_comb begin
        w_st_nxt = w_st_r;
        rx_en_nxt = 1'b0;
        w_load = 1'b0;
        case (w_st_r)
            TTA_SEQ_IDLE: begin
                // gated by the wait enable bit
                if (tx_done && wait_en) begin
                    if (wait_delay == '0) begin
                        rx_en_nxt = 1'b1;
                    end else begin
                        w_load = 1'b1;
                        w_st_nxt = TTA_SEQ_WAIT;
                    end
                end
            end
            TTA_SEQ_WAIT: begin
                if (w_done) begin
                    rx_en_nxt = 1'b1;
                    w_st_nxt = TTA_SEQ_IDLE;
                end
            end
            default: begin
                w_st_nxt = TTA_SEQ_IDLE;
            end
        endcase
    end

    // a second good frame while waiting is ignored; the first ack owns the slot
    always_comb begin
        a_st_nxt = a_st_r;
        ack_nxt = 1'b0;
        a_load = 1'b0;
        case (a_st_r)
            TTA_SEQ_IDLE: begin
                if (ack_ok) begin
                    if (ack_delay == '0) begin
                        ack_nxt = 1'b1;
                    end else begin
                        a_load = 1'b1;
                        a_st_nxt = TTA_SEQ_WAIT;
                    end
                end
            end
            TTA_SEQ_WAIT: begin
                if (a_done) begin
                    ack_nxt = 1'b1;
                    a_st_nxt = TTA_SEQ_IDLE;
                end
            end
            default: begin
                a_st_nxt = TTA_SEQ_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cfg_r <= TTA_CFG_RESET;
            ctrl_r <= TTA_CTRL_RESET;
            aw_held_r <= 1'b0;
            aw_addr_r <= '0;
            w_held_r <= 1'b0;
            w_data_r <= 32'h00000000;
            w_strb_r <= 4'h0;
            awready_r <= 1'b0;
            wready_r <= 1'b0;
            bvalid_r <= 1'b0;
            bresp_r <= TTA_RESP_OKAY;
            arready_r <= 1'b0;
            rvalid_r <= 1'b0;
            rdata_r <= 32'h00000000;
            rresp_r <= TTA_RESP_OKAY;
            w_st_r <= TTA_SEQ_IDLE;
            a_st_r <= TTA_SEQ_IDLE;
            rx_en_r <= 1'b0;
            ack_r <= 1'b0;
        end else begin
            cfg_r <= cfg_nxt;
            ctrl_r <= ctrl_nxt;
            aw_held_r <= aw_held_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_held_r <= w_held_nxt;
            w_data_r <= w_data_nxt;
            w_strb_r <= w_strb_nxt;
            awready_r <= awready_nxt;
            wready_r <= wready_nxt;
            bvalid_r <= bvalid_nxt;
            bresp_r <= bresp_nxt;
            arready_r <= arready_nxt;
            rvalid_r <= rvalid_nxt;
            rdata_r <= rdata_nxt;
            rresp_r <= rresp_nxt;
            w_st_r <= w_st_nxt;
            a_st_r <= a_st_nxt;
            rx_en_r <= rx_en_nxt;
            ack_r <= ack_nxt;
        end
    end

    assign s_axi_awready = awready_r;
    assign s_axi_wready = wready_r;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = arready_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rdata = rdata_r;
    assign s_axi_rresp = rresp_r;
    assign rx_enable = rx_en_r;
    assign ack_tx_start = ack_r;
    assign wait_busy = w_st_r[1];
    assign ack_busy = a_st_r[1];
endmodule

/* design/tta_pkg.sv */
// constants and types for the transceiver turn-around timing block
package tta_pkg;

    typedef enum logic [1:0] {
        TTA_SEQ_IDLE = 2'b01,
        TTA_SEQ_WAIT = 2'b10
    } tta_seq_t;

    localparam int TTA_ADDR_W = 8;
    localparam int TTA_DATA_W = 32;

    // register indices; byte address is four times the index
    localparam logic [7:0] TTA_IDX_TURN_CFG = 8'h1A;
    localparam logic [7:0] TTA_IDX_RSVD_A = 8'h1B;
    localparam logic [7:0] TTA_IDX_RSVD_B = 8'h1C;
    localparam logic [7:0] TTA_IDX_CTRL = 8'h20;
    localparam logic [7:0] TTA_IDX_STATUS = 8'h21;

    // turn-around config fields
    localparam int TTA_WAIT_LSB = 0;
    localparam int TTA_WAIT_W = 20;
    localparam int TTA_ACK_LSB = 24;
    localparam int TTA_ACK_W = 8;
    localparam logic [31:0] TTA_CFG_MASK = 32'hFF0FFFFF;
    localparam logic [31:0] TTA_CFG_RESET = 32'h00000000;

    // control register fields
    localparam int TTA_CTRL_WAIT_EN_BIT = 0;
    localparam int TTA_CTRL_SYM_LSB = 8;
    localparam int TTA_SYM_W = 8;
    localparam logic [31:0] TTA_CTRL_MASK = 32'h0000FF01;
    localparam logic [7:0] TTA_SYM_SYS_CYCLES = 8'h7C;
    localparam logic [31:0] TTA_CTRL_RESET = {16'h0000, TTA_SYM_SYS_CYCLES, 8'h00};

    // status register fields
    localparam int TTA_STAT_WAIT_BUSY_BIT = 0;
    localparam int TTA_STAT_ACK_BUSY_BIT = 1;

    // timing
    localparam int TTA_ACLK_MHZ = 250;
    localparam int TTA_SYS_CLK_MHZ = 125;
    localparam int TTA_SYSCLK_DIV = TTA_ACLK_MHZ / TTA_SYS_CLK_MHZ;
    localparam int TTA_UNIT_SYS_CYCLES = 128;
    localparam int TTA_DIV_W = 8;

    localparam logic [1:0] TTA_RESP_OKAY = 2'b00;
    localparam logic [1:0] TTA_RESP_SLVERR = 2'b10;

endpackage

/* design/tta_tick_div.sv */
// enable divider: one tick every period enables, restartable
`timescale 1ns/1ns
module tta_tick_div #(
    parameter int W = 8
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic clr,
    input wire logic en,
    input wire logic [W-1:0] period,
    output logic tick
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;
    logic last;

    // a period of zero or one ticks on every enable
    assign last = (period <= W'(1)) || (cnt_r >= period - W'(1));
    assign tick = en && last && !clr;

    always_comb begin
        cnt_nxt = cnt_r;
        if (clr) begin
            cnt_nxt = '0;
        end else if (en) begin
            cnt_nxt = last ? '0 : cnt_r + W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* design/tta_unit_count.sv */
// loadable down counter of delay units
`timescale 1ns/1ns
module tta_unit_count #(
    parameter int W = 20
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic load,
    input wire logic [W-1:0] load_val,
    input wire logic tick,
    output logic done
);
    logic [W-1:0] cnt_r;
    logic [W-1:0] cnt_nxt;

    assign done = tick && !load && (cnt_r == W'(1));

    always_comb begin
        cnt_nxt = cnt_r;
        if (load) begin
            cnt_nxt = load_val;
        end else if (tick && cnt_r != '0) begin
            cnt_nxt = cnt_r - W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_r <= '0;
        end else begin
            cnt_r <= cnt_nxt;
        end
    end
endmodule

/* dv/tta_top_monitor.sv */
// port checker for the turn-around timing block
`timescale 1ns/1ns
module tta_top_monitor (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic tx_done,
    input wire logic frame_good,
    input wire logic frame_ack_req,
    input wire logic frame_data_or_cmd,
    input wire logic rx_enable,
    input wire logic ack_tx_start,
    input wire logic wait_busy,
    input wire logic ack_busy
);
    import tta_pkg::*;
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
////////////////////////////////////////////////////////////////////////////////
    // bus answer timing and sequencer checks
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid) else $error("write response not two cycles after request");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data not one cycle after request");
    a_read_refused: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
    a_rx_one_pulse: assert property (rx_enable |=> !rx_enable) else $error("rx enable longer than one cycle");
    a_wait_end_rx: assert property ($fell(wait_busy) |-> rx_enable) else $error("wait ended without rx enable");
    a_wait_min_len: assert property ($rose(wait_busy) |-> wait_busy[*8]) else $error("wait far too short");
    a_wait_cause: assert property ($rose(wait_busy) |-> $past(tx_done)) else $error("wait without tx done");
    a_rx_cause: assert property (rx_enable |-> $past(tx_done) || $fell(wait_busy))
        else $error("rx enable without cause");
    a_ack_frame_ok: assert property ($rose(ack_busy) |-> $past(frame_good && frame_ack_req && frame_data_or_cmd))
        else $error("ack delay started for wrong frame");
    a_ack_cause: assert property (ack_tx_start |-> $fell(ack_busy)
        || $past(frame_good && frame_ack_req && frame_data_or_cmd)) else $error("ack start without cause");
    a_ack_one_pulse: assert property (ack_tx_start |=> !ack_tx_start) else $error("ack start too long");
    cover property ($rose(wait_busy));
    cover property ($fell(ack_busy));
    cover property (s_axi_rvalid && s_axi_rready);
endmodule
////////////////////////////////////////////////////////////////////////////////
bind tta_top tta_top_monitor mon_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_done(tx_done), .frame_good(frame_good),
    .frame_ack_req(frame_ack_req), .frame_data_or_cmd(frame_data_or_cmd), .rx_enable(rx_enable),
    .ack_tx_start(ack_tx_start), .wait_busy(wait_busy), .ack_busy(ack_busy));

/* dv/tta_top_tb.sv */
// self-checking bench for the turn-around timing block
`timescale 1ns/1ns
module tta_top_tb;
    import tta_pkg::*;
    logic aclk = 1'b0, aresetn = 1'b0;
    logic [TTA_ADDR_W-1:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
    logic [TTA_DATA_W-1:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'h0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic tx_done = 1'b0, frame_good = 1'b0, frame_ack_req = 1'b0, frame_data_or_cmd = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic rx_enable, ack_tx_start, wait_busy, ack_busy;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int fail_count = 0, num_checks = 0;

    always #2 aclk = ~aclk;

    tta_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .tx_done(tx_done), .frame_good(frame_good),
        .frame_ack_req(frame_ack_req), .frame_data_or_cmd(frame_data_or_cmd), .rx_enable(rx_enable),
        .ack_tx_start(ack_tx_start), .wait_busy(wait_busy), .ack_busy(ack_busy));
////////////////////////////////////////////////////////////////////////////////
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    function automatic logic [7:0] ba(input logic [7:0] idx);
        return {idx[5:0], 2'b00};
    endfunction

    // jitter of the slow-clock phase allows three cycles either way
    function automatic logic [31:0] win(input int n, input int e);
        return {31'h0, n >= e - 3 && n <= e + 3};
    endfunction

    // address and data offered together, each dropped once taken
    task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
        bit done;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) begin
                r = s_axi_bresp;
                s_axi_bready <= 1'b0;
                done = 1;
            end
        end
    endtask

    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        done = 0;
        while (!done) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) begin
                d = s_axi_rdata;
                r = s_axi_rresp;
                s_axi_rready <= 1'b0;
                done = 1;
            end
        end
    endtask

    // one event, repeated while the delay runs; n is the cycle of the answer, extra counts more answers
    task automatic evt(input logic frm, input logic ar, input logic dc, output int n, output int extra);
        @(posedge aclk);
        tx_done <= !frm;
        frame_good <= frm;
        frame_ack_req <= ar;
        frame_data_or_cmd <= dc;
        @(posedge aclk);
        tx_done <= 1'b0;
        frame_good <= 1'b0;
        n = 0;
        extra = 0;
        for (int i = 1; i < 1200; i++) begin
            @(posedge aclk);
            if (i == 5 && n == 0) begin
                tx_done <= !frm;
                frame_good <= frm;
            end
            if (i == 6) begin
                tx_done <= 1'b0;
                frame_good <= 1'b0;
            end
            if ((frm ? ack_tx_start : rx_enable) === 1'b1) begin
                if (n == 0) n = i;
                else extra++;
            end
        end
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (60000) @(posedge aclk);
        fail_count++;
        finish_test();
    end

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        int n, x;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        axr(ba(TTA_IDX_TURN_CFG), d, r);
        chk("cfg reset", d, 32'h0);
        axr(ba(TTA_IDX_CTRL), d, r);
        chk("ctrl reset", d, TTA_CTRL_RESET);
        axw(ba(TTA_IDX_TURN_CFG), 32'hFF0FFFFF, 4'hF, r);
        chk("cfg write resp", {30'h0, r}, 32'h0);
        axr(ba(TTA_IDX_TURN_CFG), d, r);
        chk("cfg fields", d, 32'hFF0FFFFF);
        axw(ba(TTA_IDX_TURN_CFG), 32'h5A000000, 4'h8, r);
        for (int k = 0; k < 2; k++) begin
            axr(ba(8'(TTA_IDX_RSVD_A + k)), d, r);
            chk("reserved read resp", {30'h0, r}, 32'h0);
            chk("reserved read data", d, 32'h0);
        end
        axr(ba(TTA_IDX_TURN_CFG), d, r);
        chk("cfg after lane write", d, 32'h5A0FFFFF);
        axr(ba(8'h30), d, r);
        chk("unmapped read resp", {30'h0, r}, 32'h2);
        chk("unmapped read data", d, 32'h0);
        axw(ba(8'h30), 32'h1, 4'hF, r);
        chk("unmapped write resp", {30'h0, r}, 32'h2);
        // wait function still off
        // ack delay lowered too
        axw(ba(TTA_IDX_TURN_CFG), 32'h02000001, 4'hF, r);
        evt(1'b0, 1'b0, 1'b0, n, x);
        chk("rx while disabled", n, 32'h0);
        // enable wait, ack symbol of four system clocks
        axw(ba(TTA_IDX_CTRL), 32'h00000401, 4'hF, r);
        axw(ba(TTA_IDX_TURN_CFG), 32'h0, 4'hF, r);
        evt(1'b0, 1'b0, 1'b0, n, x);
        chk("rx zero delay", n, 32'h1);
        for (int k = 1; k < 3; k++) begin
            axw(ba(TTA_IDX_TURN_CFG), 32'h02000000 | 32'(k), 4'hF, r);
            evt(1'b0, 1'b0, 1'b0, n, x);
            chk("rx delay window", win(n, 256 * k), 32'h1);
            chk("rx repeat ignored", x, 32'h0);
        end
        axw(ba(TTA_IDX_TURN_CFG), 32'h02000002, 4'hF, r);
        tx_done <= 1'b1;
        @(posedge aclk);
        tx_done <= 1'b0;
        @(posedge aclk);
        chk("wait busy pin", {31'h0, wait_busy}, 32'h1);
        axr(ba(TTA_IDX_STATUS), d, r);
        chk("status while waiting", d, 32'h1);
        repeat (600) @(posedge aclk);
        chk("wait busy cleared", {31'h0, wait_busy}, 32'h0);
        axw(ba(TTA_IDX_TURN_CFG), 32'h0, 4'hF, r);
        evt(1'b1, 1'b1, 1'b1, n, x);
        chk("ack zero delay", n, 32'h1);
        evt(1'b1, 1'b0, 1'b1, n, x);
        chk("ack not asked", n, 32'h0);
        evt(1'b1, 1'b1, 1'b0, n, x);
        chk("ack wrong frame kind", n, 32'h0);
        axw(ba(TTA_IDX_TURN_CFG), 32'h02000001, 4'hF, r);
        evt(1'b1, 1'b1, 1'b1, n, x);
        chk("ack delay window", win(n, 16), 32'h1);
        chk("ack repeat ignored", x, 32'h0);
        frame_good <= 1'b1;
        @(posedge aclk);
        frame_good <= 1'b0;
        @(posedge aclk);
        chk("ack busy pin", {31'h0, ack_busy}, 32'h1);
        repeat (30) @(posedge aclk);
        chk("ack busy cleared", {31'h0, ack_busy}, 32'h0);
        finish_test();
    end
endmodule
